/* File: lps_consts.vh */
// Constants for the low-power mode sequencer
// Notes on behaviour
// - Standby instruction from active enters standby
// - Peripherals keep running in standby
// - Interrupt leaves standby, resumes next instruction
// - Asynchronous reset ends every mode
// - Stop instruction, watch-select clear, enters stop
// - Sub oscillator stop bit applies in stop
// - Stop exit restarts at zero, sets RAM flag
// - Stop-cancel ignored outside stop mode
// - CPU context not kept across stop
// - Stop instruction, watch-select set, enters watch
// - Timer A or ext irq0 leaves watch
// - Watch wake takes settle or frame delay
// - Subactive runs on sub clock, no ADC
// - Sub divide bit changes only in active
// - Direct transfer from subactive to active
// - Direct-transfer flag only set in subactive
// - Frame length picked from three values
// - Slow-mode requests issued on frame strobe
// - Ext irq0 sampled once per frame
// - Low-power instruction with blocked irq is nop
// - Pins kept, tristated in stop, inputs gated
// - Serial interrupt suppressed in watch mode
`ifndef LPS_CONSTS_VH
`define LPS_CONSTS_VH
`define LPS_A_CTRL 12'h000
`define LPS_A_STAT 12'h004
`define LPS_B_LOW_SPEED_ON_FLAG 0
`define LPS_B_WSEL 1
`define LPS_B_SDIV 2
`define LPS_B_DIRECT_TRANSFER_ON_FLAG 3
`define LPS_B_SOSC 4
`define LPS_F_FSEL 6:5
`define LPS_CTRL_W 7
`define LPS_CTRL_RST 7'h00
`define LPS_B_RAM_ENABLE_FLAG 8
`define LPS_ST_W 7
`define LPS_CLK_KHZ 20000
`define LPS_SETTLE_US 1000
`define LPS_FRAME0_US 500
`define LPS_FRAME1_US 2000
`define LPS_FRAME2_US 8000
`define LPS_US_PER_MS 1000
`define LPS_CNT_W 24
`endif

/* File: lps_sequencer.v */
// Low-power mode sequencer with APB register access
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "lps_consts.vh"
module lps_sequencer #(
   parameter [23:0] SETTLE_CYC = (`LPS_SETTLE_US * `LPS_CLK_KHZ
      + `LPS_US_PER_MS - 1) / `LPS_US_PER_MS,
   parameter [23:0] FRAME0_CYC = (`LPS_FRAME0_US * `LPS_CLK_KHZ
      + `LPS_US_PER_MS - 1) / `LPS_US_PER_MS,
   parameter [23:0] FRAME1_CYC = (`LPS_FRAME1_US * `LPS_CLK_KHZ
      + `LPS_US_PER_MS - 1) / `LPS_US_PER_MS,
   parameter [23:0] FRAME2_CYC = (`LPS_FRAME2_US * `LPS_CLK_KHZ
      + `LPS_US_PER_MS - 1) / `LPS_US_PER_MS
) (
   input wire sys_clk,
   input wire arst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire stop_instr,
   input wire standby_instr,
   input wire interrupt_enable_flag,
   input wire irq_pending,
   input wire timer_a_ovf,
   input wire ext_irq0_n,
   input wire stop_cancel_n,
   output wire [6:0] mode_state,
   output reg main_osc_en,
   output reg sub_osc_en,
   output reg cpu_clk_en,
   output reg periph_clk_en,
   output reg timer_a_clk_en,
   output reg adc_en,
   output reg serial_irq_en,
   output reg cpu_hold_reset,
   output reg pin_out_hiz,
   output reg pin_in_en,
   output reg restart_at_zero,
   output reg resume_next,
   output reg irq_service,
   output reg instr_nop,
   output reg ram_enable_flag,
   output reg sub_clock_divide_bit,
   output reg timer_a_irq_out,
   output reg ext_irq0_out,
   output reg frame_strobe
);
   localparam [6:0] S_ACT = 7'h01;
   localparam [6:0] S_STBY = 7'h02;
   localparam [6:0] S_STOP = 7'h04;
   localparam [6:0] S_WATCH = 7'h08;
   localparam [6:0] S_SUB = 7'h10;
   localparam [6:0] S_DTW = 7'h20;
   localparam [6:0] S_SETL = 7'h40;
   localparam [23:0] SET_LAST = SETTLE_CYC - 24'h000001;

   reg [6:0] st_r;
   reg [6:0] st_nxt;
   reg [`LPS_CTRL_W-1:0] ctrl_r;
   reg [`LPS_CNT_W-1:0] cnt_r;
   reg [`LPS_CNT_W-1:0] cnt_nxt;
   reg [`LPS_CNT_W-1:0] fcnt_r;
   reg [`LPS_CNT_W-1:0] flen;
   reg ta_pend_r;
   reg e0_s_r;
   reg e0_pend_r;
   reg e0_d_r;
   reg go_resume;
   reg go_restart;
   reg nop;

   wire low_speed_on_flag = ctrl_r[`LPS_B_LOW_SPEED_ON_FLAG];
   wire wsel = ctrl_r[`LPS_B_WSEL];
   wire direct_transfer_on_flag = ctrl_r[`LPS_B_DIRECT_TRANSFER_ON_FLAG];
   wire sosc = ctrl_r[`LPS_B_SOSC];
   wire lp_instr = stop_instr | standby_instr;
   wire blocked = ~interrupt_enable_flag & irq_pending;
   wire slow = (st_r == S_WATCH) | (st_r == S_SUB) | (st_r == S_DTW);
   wire fend = (fcnt_r == flen - 24'h000001);
   wire strobe = slow & fend;
   wire wake_ta = strobe & ta_pend_r;
   wire wake_e0 = strobe & e0_pend_r;
   wire done = (cnt_r == SET_LAST);
   wire acc = psel & penable & pready;
   wire wr_ctrl = acc & pwrite & (paddr == `LPS_A_CTRL);

   assign mode_state = st_r;

   // Values above two fall back to the longest frame
   always @* begin
      case (ctrl_r[`LPS_F_FSEL])
         2'h0: flen = FRAME0_CYC;
         2'h1: flen = FRAME1_CYC;
         default: flen = FRAME2_CYC;
      endcase
   end

   always @* begin
      st_nxt = st_r;
      go_resume = 1'b0;
      go_restart = 1'b0;
      nop = 1'b0;
      case (st_r)
         S_ACT: begin
            if (lp_instr & blocked) begin
               nop = 1'b1;
            end else if (standby_instr) begin
               st_nxt = S_STBY;
            end else if (stop_instr) begin
               st_nxt = wsel ? S_WATCH : S_STOP;
            end
         end
         S_STBY: begin
            if (irq_pending) begin
               st_nxt = S_ACT;
               go_resume = 1'b1;
            end
         end
         S_STOP: begin
            // Cancel pin is looked at only here
            if (~stop_cancel_n & done) begin
               st_nxt = S_ACT;
               go_restart = 1'b1;
            end
         end
         S_WATCH: begin
            if (wake_ta | wake_e0) begin
               if (low_speed_on_flag) begin
                  st_nxt = S_SUB;
                  go_resume = 1'b1;
               end else begin
                  st_nxt = S_SETL;
               end
            end
         end
         S_SUB: begin
            if (lp_instr & blocked) begin
               nop = 1'b1;
            end else if (lp_instr & ~low_speed_on_flag & direct_transfer_on_flag) begin
               st_nxt = S_DTW;
            end else if (lp_instr) begin
               st_nxt = S_WATCH;
            end
         end
         S_DTW: begin
            // Internal processing ends on the next frame strobe
            if (strobe) begin
               st_nxt = S_SETL;
            end
         end
         S_SETL: begin
            if (done) begin
               st_nxt = S_ACT;
               go_resume = 1'b1;
            end
         end
         default: begin
            st_nxt = S_ACT;
         end
      endcase
   end

   // One counter serves both cancel hold and oscillator settling
   always @* begin
      cnt_nxt = {`LPS_CNT_W{1'b0}};
      if ((st_r == S_STOP) & ~stop_cancel_n & ~done) begin
         cnt_nxt = cnt_r + 24'h000001;
      end else if ((st_r == S_SETL) & ~done) begin
         cnt_nxt = cnt_r + 24'h000001;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= S_ACT;
         cnt_r <= {`LPS_CNT_W{1'b0}};
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Frame timebase runs only in the slow modes
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         fcnt_r <= {`LPS_CNT_W{1'b0}};
      end else if (!slow | fend) begin
         fcnt_r <= {`LPS_CNT_W{1'b0}};
      end else begin
         fcnt_r <= fcnt_r + 24'h000001;
      end
   end

   // New overflow beats the strobe clear so none is lost
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ta_pend_r <= 1'b0;
         e0_s_r <= 1'b1;
         e0_pend_r <= 1'b0;
         e0_d_r <= 1'b1;
      end else begin
         e0_d_r <= ext_irq0_n;
         if (!slow) begin
            ta_pend_r <= 1'b0;
            // Track the pin so a level already low is no edge
            e0_s_r <= ext_irq0_n;
            e0_pend_r <= 1'b0;
         end else begin
            ta_pend_r <= timer_a_ovf | (ta_pend_r & ~strobe);
            if (strobe) begin
               e0_s_r <= ext_irq0_n;
               e0_pend_r <= e0_s_r & ~ext_irq0_n;
            end
         end
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= `LPS_CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r[`LPS_B_LOW_SPEED_ON_FLAG] <= pwdata[`LPS_B_LOW_SPEED_ON_FLAG];
            ctrl_r[`LPS_B_WSEL] <= pwdata[`LPS_B_WSEL];
            ctrl_r[`LPS_B_SOSC] <= pwdata[`LPS_B_SOSC];
            ctrl_r[`LPS_F_FSEL] <= pwdata[`LPS_F_FSEL];
            if (st_r == S_ACT) begin
               ctrl_r[`LPS_B_SDIV] <= pwdata[`LPS_B_SDIV];
            end
         end
         if (st_r == S_ACT) begin
            ctrl_r[`LPS_B_DIRECT_TRANSFER_ON_FLAG] <= 1'b0;
         end else if (wr_ctrl & (st_r == S_SUB)) begin
            ctrl_r[`LPS_B_DIRECT_TRANSFER_ON_FLAG] <= pwdata[`LPS_B_DIRECT_TRANSFER_ON_FLAG];
         end
      end
   end

   // Zero-wait slave: ready in the first access cycle
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (psel & ~penable) begin
            if (paddr == `LPS_A_CTRL) begin
               prdata[`LPS_CTRL_W-1:0] <= ctrl_r;
            end else if (paddr == `LPS_A_STAT) begin
               prdata[`LPS_ST_W-1:0] <= st_r;
               prdata[`LPS_B_RAM_ENABLE_FLAG] <= ram_enable_flag;
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ram_enable_flag <= 1'b0;
      end else if (go_restart) begin
         ram_enable_flag <= 1'b1;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         main_osc_en <= 1'b1;
         sub_osc_en <= 1'b1;
         cpu_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         timer_a_clk_en <= 1'b1;
         adc_en <= 1'b1;
         serial_irq_en <= 1'b1;
         cpu_hold_reset <= 1'b0;
         pin_out_hiz <= 1'b0;
         pin_in_en <= 1'b1;
         restart_at_zero <= 1'b0;
         resume_next <= 1'b0;
         irq_service <= 1'b0;
         instr_nop <= 1'b0;
         sub_clock_divide_bit <= 1'b0;
         timer_a_irq_out <= 1'b0;
         ext_irq0_out <= 1'b0;
         frame_strobe <= 1'b0;
      end else begin
         main_osc_en <= (st_nxt == S_ACT) | (st_nxt == S_STBY)
            | (st_nxt == S_SETL);
         sub_osc_en <= ~((st_nxt == S_STOP) & sosc);
         cpu_clk_en <= (st_nxt == S_ACT) | (st_nxt == S_SUB);
         periph_clk_en <= (st_nxt == S_ACT) | (st_nxt == S_STBY)
            | (st_nxt == S_SUB);
         timer_a_clk_en <= (st_nxt != S_STOP);
         adc_en <= (st_nxt == S_ACT) | (st_nxt == S_STBY);
         serial_irq_en <= (st_nxt != S_WATCH)
            & (st_nxt != S_STOP);
         // Context registers are not kept, the core sits in reset
         cpu_hold_reset <= (st_nxt == S_STOP);
         pin_out_hiz <= (st_nxt == S_STOP);
         pin_in_en <= (st_nxt == S_ACT) | (st_nxt == S_SUB);
         restart_at_zero <= go_restart;
         resume_next <= go_resume;
         irq_service <= go_resume & interrupt_enable_flag;
         instr_nop <= nop;
         sub_clock_divide_bit <= ctrl_r[`LPS_B_SDIV];
         frame_strobe <= strobe;
         if (slow) begin
            timer_a_irq_out <= wake_ta;
            ext_irq0_out <= wake_e0;
         end else begin
            timer_a_irq_out <= timer_a_ovf & (st_r != S_STOP);
            ext_irq0_out <= e0_d_r & ~ext_irq0_n & (st_r != S_STOP);
         end
      end
   end
endmodule // lps_sequencer

/* File: lps_seq_props.sv */
// Checker for the low-power mode sequencer ports
`timescale 1ns/100ps
module lps_seq_props #(
   parameter [23:0] SETTLE_CYC = 24'h8
) (
   input wire sys_clk,
   input wire arst_n,
   input wire stop_instr,
   input wire standby_instr,
   input wire interrupt_enable_flag,
   input wire irq_pending,
   input wire stop_cancel_n,
   input wire [6:0] mode_state,
   input wire main_osc_en,
   input wire cpu_clk_en,
   input wire periph_clk_en,
   input wire timer_a_clk_en,
   input wire serial_irq_en,
   input wire pin_out_hiz,
   input wire restart_at_zero,
   input wire resume_next,
   input wire instr_nop,
   input wire ram_enable_flag,
   input wire sub_clock_divide_bit
);
   // Cancel-low samples in stop; a short pulse must never wake the part
   reg [23:0] cnl_r;
   wire blk = !interrupt_enable_flag && irq_pending;
   wire lp_in = stop_instr || standby_instr;
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n)
         cnl_r <= 24'h0;
      else if (mode_state == 7'h04 && !stop_cancel_n)
         cnl_r <= cnl_r + 24'h1;
      else
         cnl_r <= 24'h0;
   end
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_nop_req;
      mode_state == 7'h01 && lp_in && blk;
   endsequence
   sequence s_nop_ack;
      instr_nop && mode_state == 7'h01;
   endsequence
   AST_SBY: assert property (mode_state == 7'h01 && standby_instr
      && !stop_instr && !blk |=> mode_state == 7'h02)
      else $error("standby entry missed");
   AST_SBY_CLK: assert property (mode_state == 7'h02 |->
      main_osc_en && !cpu_clk_en && periph_clk_en)
      else $error("standby clock gating wrong");
   AST_WAKE: assert property (mode_state == 7'h02 && irq_pending
      |=> mode_state == 7'h01 && resume_next)
      else $error("standby wake missed");
   AST_STOP: assert property (mode_state == 7'h04 |->
      !main_osc_en && pin_out_hiz)
      else $error("stop outputs wrong");
   AST_EARLY: assert property (mode_state == 7'h04
      && cnl_r < SETTLE_CYC - 24'h1 |=> mode_state != 7'h01)
      else $error("stop left too early");
   AST_RESTART: assert property (restart_at_zero |->
      mode_state == 7'h01 && ram_enable_flag && $past(mode_state) == 7'h04)
      else $error("restart without stop exit");
   AST_IGNORE: assert property (mode_state == 7'h01 && !lp_in
      |=> mode_state == 7'h01 && !restart_at_zero)
      else $error("active left without instruction");
   AST_WATCH: assert property (mode_state == 7'h08 |->
      !main_osc_en && timer_a_clk_en && !serial_irq_en)
      else $error("watch gating wrong");
   AST_SDIV: assert property ($changed(sub_clock_divide_bit) |->
      $past(mode_state, 2) == 7'h01)
      else $error("divide bit changed outside active");
   AST_NOP: assert property (s_nop_req |=> s_nop_ack)
      else $error("blocked instruction not a no-op");
   AST_HOT: assert property ($onehot(mode_state))
      else $error("mode not one-hot");
endmodule // lps_seq_props

/* File: lps_cpu_model.sv */
// CPU-side partner: decoder pulses, interrupt flag, timer overflow
`timescale 1ns/100ps
module lps_cpu_model (
   input wire sys_clk,
   input wire arst_n,
   input wire req_stop,
   input wire req_sby,
   input wire req_ovf,
   input wire pend_in,
   input wire irq_service,
   output reg stop_instr,
   output reg standby_instr,
   output reg timer_a_ovf,
   output reg irq_pending
);
   // Pulses lag the request by one clock, as a decoder would
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stop_instr <= 1'b0;
         standby_instr <= 1'b0;
         timer_a_ovf <= 1'b0;
         irq_pending <= 1'b0;
      end else begin
         stop_instr <= req_stop;
         standby_instr <= req_sby;
         timer_a_ovf <= req_ovf;
         // Serviced flag drops; a held request raises it again
         irq_pending <= pend_in & ~irq_service;
      end
   end
endmodule // lps_cpu_model

/* File: lps_sequencer_bench.sv */
// Testbench for the low-power mode sequencer
`timescale 1ns/100ps
module lps_sequencer_bench;
   reg sys_clk = 1'b0;
   reg arst_n = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   reg interrupt_enable_flag = 1'b1;
   reg ext_irq0_n = 1'b1;
   reg stop_cancel_n = 1'b1;
   reg req_stop = 1'b0;
   reg req_sby = 1'b0;
   reg req_ovf = 1'b0;
   reg pend_in = 1'b0;
   wire [31:0] prdata;
   wire [6:0] mode_state;
   wire pready, pslverr, stop_instr, standby_instr, irq_pending;
   wire timer_a_ovf, main_osc_en, sub_osc_en, cpu_clk_en, periph_clk_en;
   wire timer_a_clk_en, adc_en, serial_irq_en, cpu_hold_reset, pin_out_hiz;
   wire pin_in_en, restart_at_zero, resume_next, irq_service, instr_nop;
   wire ram_enable_flag, sub_clock_divide_bit;
   wire timer_a_irq_out, ext_irq0_out, frame_strobe;
   integer miscompares = 0;
   integer n_compared = 0;
   integer cyc = 0;
   integer i;
   reg [31:0] rd;
   reg er;
   integer fs;
   reg e0s;
   // Frame and settle lengths given to the instance below
   localparam FR = 8;
   localparam ST = 8;
   // Rows: write, offset, write data, read data, error
   reg [21:0] rows [0:5] = '{{1'b1, 4'h0, 8'h7F, 8'h00, 1'b0},
      {1'b0, 4'h0, 8'h00, 8'h77, 1'b0}, {1'b1, 4'h8, 8'h55, 8'h00, 1'b1},
      {1'b0, 4'h8, 8'h00, 8'h00, 1'b1}, {1'b1, 4'h0, 8'h00, 8'h00, 1'b0},
      {1'b0, 4'h4, 8'h00, 8'h01, 1'b0}};
   lps_sequencer #(.SETTLE_CYC(24'h8), .FRAME0_CYC(24'h4),
      .FRAME1_CYC(24'h6), .FRAME2_CYC(24'h8)) dut (
      .sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .stop_instr, .standby_instr, .interrupt_enable_flag,
      .irq_pending, .timer_a_ovf, .ext_irq0_n, .stop_cancel_n, .mode_state,
      .main_osc_en, .sub_osc_en, .cpu_clk_en, .periph_clk_en, .timer_a_clk_en,
      .adc_en, .serial_irq_en, .cpu_hold_reset, .pin_out_hiz, .pin_in_en,
      .restart_at_zero, .resume_next, .irq_service, .instr_nop,
      .ram_enable_flag, .sub_clock_divide_bit, .timer_a_irq_out,
      .ext_irq0_out, .frame_strobe);
   lps_cpu_model cpu (.sys_clk, .arst_n, .req_stop, .req_sby, .req_ovf,
      .pend_in, .irq_service, .stop_instr, .standby_instr, .timer_a_ovf,
      .irq_pending);
   task end_sim;
      begin
         if (miscompares == 0 && n_compared > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
         end
      end
   endtask
   // Waiting at the start keeps two transfers off one time step
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge sys_clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge sys_clk);
         penable <= 1'b1;
         @(posedge sys_clk);
         while (pready !== 1'b1) @(posedge sys_clk);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task op(input [1:0] k);
      begin
         @(posedge sys_clk);
         req_sby <= (k == 2'd0);
         req_stop <= (k == 2'd1);
         req_ovf <= (k == 2'd2);
         @(posedge sys_clk);
         {req_sby, req_stop, req_ovf} <= 3'h0;
      end
   endtask
   task wm(input [6:0] m);
      integer j;
      begin
         for (j = 0; j < 60 && mode_state !== m; j = j + 1)
            @(posedge sys_clk);
         chk({25'h0, mode_state}, {25'h0, m});
      end
   endtask
   initial forever #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         miscompares = miscompares + 1;
         end_sim;
      end
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      chk({24'h0, ram_enable_flag, mode_state}, 32'h01);
      for (i = 0; i < 6; i = i + 1) begin
         apb(rows[i][21], {8'h0, rows[i][20:17]}, {24'h0, rows[i][16:9]});
         if (!rows[i][21])
            chk(rd, {24'h0, rows[i][8:1]});
         chk({31'h0, er}, {31'h0, rows[i][0]});
      end
      op(2'd0);
      wm(7'h02);
      chk({28'h0, main_osc_en, cpu_clk_en, periph_clk_en, sub_osc_en},
         32'hB);
      pend_in <= 1'b1;
      wm(7'h01);
      chk({31'h0, irq_service}, 32'h1);
      interrupt_enable_flag <= 1'b0;
      repeat (2) @(posedge sys_clk);
      op(2'd1);
      repeat (2) @(posedge sys_clk);
      chk({24'h0, instr_nop, mode_state}, 32'h81);
      interrupt_enable_flag <= 1'b1;
      pend_in <= 1'b0;
      repeat (2) @(posedge sys_clk);
      op(2'd1);
      wm(7'h04);
      chk({28'h0, cpu_hold_reset, main_osc_en, pin_out_hiz, pin_in_en},
         32'hA);
      stop_cancel_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      stop_cancel_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      wm(7'h04);
      stop_cancel_n <= 1'b0;
      // Early release must restart the hold count
      repeat (8) @(posedge sys_clk);
      wm(7'h04);
      wm(7'h01);
      stop_cancel_n <= 1'b1;
      chk({31'h0, ram_enable_flag}, 32'h1);
      apb(1'b1, 12'h000, 32'h10);
      op(2'd1);
      wm(7'h04);
      chk({31'h0, sub_osc_en}, 32'h0);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      chk({24'h0, ram_enable_flag, mode_state}, 32'h01);
      apb(1'b1, 12'h000, 32'h07);
      op(2'd1);
      wm(7'h08);
      op(2'd2);
      wm(7'h10);
      chk({31'h0, timer_a_irq_out}, 32'h1);
      chk({31'h0, adc_en}, 32'h0);
      apb(1'b1, 12'h000, 32'h0C);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0C);
      chk({31'h0, sub_clock_divide_bit}, 32'h1);
      op(2'd0);
      wm(7'h20);
      wm(7'h01);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h04);
      apb(1'b1, 12'h000, 32'h42);
      op(2'd1);
      wm(7'h08);
      while (frame_strobe !== 1'b1) @(posedge sys_clk);
      // Pin held low until active, longer than one frame
      ext_irq0_n <= 1'b0;
      i = 0;
      fs = 0;
      e0s = 1'b0;
      while (mode_state !== 7'h01 && i < 60) begin
         @(posedge sys_clk);
         i = i + 1;
         fs = fs + frame_strobe;
         e0s = e0s | ext_irq0_out;
      end
      ext_irq0_n <= 1'b1;
      chk({31'h0, e0s}, 32'h1);
      chk(fs, 2);
      chk({31'h0, i > FR + ST + 1 && i < 2 * FR + ST + 1},
         32'h1);
      end_sim;
   end
endmodule // lps_sequencer_bench
bind lps_sequencer lps_seq_props #(.SETTLE_CYC(SETTLE_CYC)) chk_u (.*);
